// *** exposure_loop_defs.vh ***
// constants of the exposure loop configuration register bank
// assumes one 10 MHz clock and a synchronous active-high reset
`ifndef EXPOSURE_LOOP_DEFS_VH
`define EXPOSURE_LOOP_DEFS_VH

// register indices, byte address is four times the index
`define IDX_CTRL        8'hA0
`define IDX_TARGET      8'hA1
`define IDX_RED_W       8'hA2
`define IDX_G1_W        8'hA3
`define IDX_G2_W        8'hA4
`define IDX_BLUE_W      8'hA5
`define IDX_STATUS      8'hBE
`define IDX_GAINS       8'hBF

// reset values
`define RST_CTRL        16'h0010
`define RST_TARGET      16'h60B8
`define RST_WEIGHT      10'h080
`define RST_DGAIN       12'h080
`define RST_STAGE       2'h0

// control field positions
`define CTRL_ENABLE     0
`define CTRL_RESTART    1
`define CTRL_FREEZE     2
`define CTRL_SUBSAMPLE  3
`define CTRL_PRIORITY   4

// target field positions
`define TGT_LEVEL_MSB   9
`define TGT_CLIP_MSB    13
`define TGT_CLIP_LSB    10

// fixed point and filter figures
`define WEIGHT_FRAC     7
`define CLIP_FRAC       3
`define FILT_SHIFT      4
`define STAGE_MAX       2'h3
`define DGAIN_MAX       12'hFFF
`define DGAIN_STEP      12'h004
`define PIX_MAX         10'h3FF

`endif

// *** exposure_loop_config_regs.v ***
// exposure loop configuration registers with statistics and gain stepping
// assumes an Avalon-MM master with waitrequest and a pixel stream on CLK
`timescale 1ns/1ps
`include "exposure_loop_defs.vh"

module exposure_loop_config_regs (
	// clock and reset
	input  wire        CLK,
	input  wire        SYS_RST,
	// avalon-mm slave
	input  wire [9:0]  ADDRESS,
	input  wire        READ,
	input  wire        WRITE,
	input  wire [3:0]  BYTEENABLE,
	input  wire [31:0] WRITEDATA,
	output reg  [31:0] READDATA,
	output reg         WAITREQUEST,
	// pixel stream
	input  wire        PIX_VALID,
	input  wire [9:0]  PIX_DATA,
	input  wire [1:0]  PIX_COLOR,
	input  wire        FRAME_END,
	// loop results
	output reg  [1:0]  GAIN_STAGE1,
	output reg  [1:0]  GAIN_STAGE2,
	output reg  [11:0] DIGITAL_GAIN,
	output reg  [9:0]  AVG_LEVEL,
	output reg         LOOP_ACTIVE
);

	// register state
	reg  [4:0]  ctrl_r;
	reg  [15:0] target_r;
	wire [9:0]  weight [0:3];
	wire [15:0] ctrl_rst;
	assign ctrl_rst = `RST_CTRL;
	reg         restart_r;
	reg  [1:0]  sub_cnt_r;
	reg  [13:0] acc_r;
	reg  [7:0]  frame_cnt_r;
	reg         above_r;

	// bus decode
	wire [7:0]  idx;
	wire        req;
	wire        wr_now;
	wire        rd_now;
	wire [15:0] wr_mask;
	assign idx     = ADDRESS[9:2];
	assign req     = READ | WRITE;
	assign wr_now  = WRITE & ~WAITREQUEST;
	assign rd_now  = READ & WAITREQUEST;
	assign wr_mask = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};

	function [15:0] merge;
		input [15:0] old_v;
		input [15:0] new_v;
		input [15:0] mask;
		begin
			merge = (old_v & ~mask) | (new_v & mask);
		end
	endfunction

	// control fields
	wire        en_b;
	wire        freeze_b;
	wire        sub_b;
	wire        pri_b;
	wire        run;
	assign en_b     = ctrl_r[`CTRL_ENABLE];
	assign freeze_b = ctrl_r[`CTRL_FREEZE];
	assign sub_b    = ctrl_r[`CTRL_SUBSAMPLE];
	assign pri_b    = ctrl_r[`CTRL_PRIORITY];
	assign run      = en_b & ~freeze_b;

	// waitrequest: one wait state, then one ready cycle
	always @(posedge CLK) begin
		if (SYS_RST) begin
			WAITREQUEST <= 1'b1;
		end else if (req & WAITREQUEST) begin
			WAITREQUEST <= 1'b0;
		end else begin
			WAITREQUEST <= 1'b1;
		end
	end

	// control and target registers
	reg [15:0] ctrl_w;
	always @* begin
		ctrl_w = merge({11'h000, ctrl_r}, WRITEDATA[15:0], wr_mask);
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_r    <= ctrl_rst[4:0];
			target_r  <= `RST_TARGET;
			restart_r <= 1'b0;
		end else begin
			restart_r <= 1'b0;
			if (wr_now && idx == `IDX_CTRL) begin
				ctrl_r <= {ctrl_w[4:2], 1'b0, ctrl_w[0]};
				restart_r <= ctrl_w[`CTRL_RESTART];
			end
			if (wr_now && idx == `IDX_TARGET) begin
				target_r <= merge(target_r, WRITEDATA[15:0], wr_mask);
			end
		end
	end

	// per-colour weight registers
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_weight
			reg [9:0]  w_r;
			reg [15:0] w_m;
			assign weight[gi] = w_r;
			always @* begin
				w_m = merge({6'h00, w_r}, WRITEDATA[15:0], wr_mask);
			end
			always @(posedge CLK) begin
				if (SYS_RST) begin
					w_r <= `RST_WEIGHT;
				end else if (wr_now && idx == `IDX_RED_W + gi) begin
					w_r <= w_m[9:0];
				end
			end
		end
	endgenerate

	// read data
	reg [15:0] rd_val;
	always @* begin
		case (idx)
			`IDX_CTRL:   rd_val = {11'h000, ctrl_r};
			`IDX_TARGET: rd_val = target_r;
			`IDX_RED_W:  rd_val = {6'h00, weight[0]};
			`IDX_G1_W:   rd_val = {6'h00, weight[1]};
			`IDX_G2_W:   rd_val = {6'h00, weight[2]};
			`IDX_BLUE_W: rd_val = {6'h00, weight[3]};
			`IDX_STATUS: rd_val = {frame_cnt_r[3:0], above_r, LOOP_ACTIVE, AVG_LEVEL};
			`IDX_GAINS:  rd_val = {DIGITAL_GAIN, GAIN_STAGE2, GAIN_STAGE1};
			default:     rd_val = 16'h0000;
		endcase
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			READDATA <= 32'h00000000;
		end else if (rd_now) begin
			READDATA <= {16'h0000, rd_val};
		end
	end

	// pixel selection: every pixel or every fourth
	wire take;
	assign take = PIX_VALID & (~sub_b | (sub_cnt_r == 2'h0));

	always @(posedge CLK) begin
		if (SYS_RST) begin
			sub_cnt_r <= 2'h0;
		end else if (PIX_VALID) begin
			sub_cnt_r <= sub_cnt_r + 2'h1;
		end
	end

	// weighting in unsigned 3.7
	wire [19:0] prod;
	wire [12:0] scaled;
	wire [9:0]  sample;
	assign prod   = PIX_DATA * weight[PIX_COLOR];
	assign scaled = prod[19:`WEIGHT_FRAC];
	assign sample = (scaled > {3'b000, `PIX_MAX}) ? `PIX_MAX : scaled[9:0];

	// running average filter
	wire [13:0] acc_dec;
	wire [13:0] acc_nxt;
	assign acc_dec = acc_r >> `FILT_SHIFT;
	assign acc_nxt = acc_r - acc_dec + {4'h0, sample};

	always @(posedge CLK) begin
		if (SYS_RST) begin
			acc_r <= {target_r[`TGT_LEVEL_MSB:0], 4'h0};
		end else if (restart_r) begin
			acc_r <= {target_r[`TGT_LEVEL_MSB:0], 4'h0};
		end else if (run && take) begin
			acc_r <= acc_nxt;
		end
	end

	// clipped target: average times clip factor in 1.3
	wire [9:0]  avg;
	wire [3:0]  clip;
	wire [15:0] clip_prod;
	wire [12:0] clip_lvl;
	wire [9:0]  tgt_lvl;
	wire [9:0]  eff_tgt;
	assign avg       = acc_r[13:4];
	assign clip      = target_r[`TGT_CLIP_MSB:`TGT_CLIP_LSB];
	assign clip_prod = {6'h00, avg} * {12'h000, clip};
	assign clip_lvl  = clip_prod[15:`CLIP_FRAC];
	assign tgt_lvl   = target_r[`TGT_LEVEL_MSB:0];
	assign eff_tgt   = (clip_lvl < {3'b000, tgt_lvl}) ? clip_lvl[9:0] : tgt_lvl;

	// gain stepping at frame end
	wire up;
	wire down;
	wire s1_max;
	wire s2_max;
	wire s1_min;
	wire s2_min;
	wire dg_max;
	wire dg_min;
	assign up     = avg < eff_tgt;
	assign down   = avg > tgt_lvl;
	assign s1_max = GAIN_STAGE1 == `STAGE_MAX;
	assign s2_max = GAIN_STAGE2 == `STAGE_MAX;
	assign s1_min = GAIN_STAGE1 == `RST_STAGE;
	assign s2_min = GAIN_STAGE2 == `RST_STAGE;
	assign dg_max = DIGITAL_GAIN > `DGAIN_MAX - `DGAIN_STEP;
	assign dg_min = DIGITAL_GAIN <= `RST_DGAIN;

	always @(posedge CLK) begin
		if (SYS_RST) begin
			GAIN_STAGE1  <= `RST_STAGE;
			GAIN_STAGE2  <= `RST_STAGE;
			DIGITAL_GAIN <= `RST_DGAIN;
		end else if (FRAME_END && run) begin
			if (up) begin
				if (pri_b && !s1_max) begin
					GAIN_STAGE1 <= GAIN_STAGE1 + 2'h1;
				end else if (!s2_max) begin
					GAIN_STAGE2 <= GAIN_STAGE2 + 2'h1;
				end else if (!s1_max) begin
					GAIN_STAGE1 <= GAIN_STAGE1 + 2'h1;
				end else if (!dg_max) begin
					DIGITAL_GAIN <= DIGITAL_GAIN + `DGAIN_STEP;
				end
			end else if (down) begin
				if (!dg_min) begin
					DIGITAL_GAIN <= DIGITAL_GAIN - `DGAIN_STEP;
				end else if (pri_b && !s2_min) begin
					GAIN_STAGE2 <= GAIN_STAGE2 - 2'h1;
				end else if (!s1_min) begin
					GAIN_STAGE1 <= GAIN_STAGE1 - 2'h1;
				end else if (!s2_min) begin
					GAIN_STAGE2 <= GAIN_STAGE2 - 2'h1;
				end
			end
		end
	end

	// status outputs
	always @(posedge CLK) begin
		if (SYS_RST) begin
			AVG_LEVEL   <= 10'h000;
			LOOP_ACTIVE <= 1'b0;
			above_r     <= 1'b0;
			frame_cnt_r <= 8'h00;
		end else begin
			AVG_LEVEL   <= avg;
			LOOP_ACTIVE <= run;
			above_r     <= down;
			if (FRAME_END && run) begin
				frame_cnt_r <= frame_cnt_r + 8'h01;
			end
		end
	end

endmodule // exposure_loop_config_regs

// *** _unused_placeholder_removed.v ***
`timescale 1ns/1ps

// *** exposure_loop_asserts.sv ***
// checker for the exposure loop register bank ports
// assumes binding onto exposure_loop_config_regs
`timescale 1ns/1ps
`include "exposure_loop_defs.vh"
module exposure_loop_asserts (
	// clock and reset
	input wire        CLK,
	input wire        SYS_RST,
	// bus and loop
	input wire        READ,
	input wire        WRITE,
	input wire [31:0] READDATA,
	input wire        WAITREQUEST,
	input wire        FRAME_END,
	input wire [1:0]  GAIN_STAGE1,
	input wire [1:0]  GAIN_STAGE2,
	input wire [11:0] DIGITAL_GAIN,
	input wire        LOOP_ACTIVE
);
	wire [15:0] gains = {DIGITAL_GAIN, GAIN_STAGE2, GAIN_STAGE1};
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	a_wait_pulse: assert property (!WAITREQUEST |=> WAITREQUEST)
		else $error("wait low twice");
	a_wait_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
		else $error("no answer");
	a_read_upper: assert property (!WAITREQUEST |-> READDATA[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_freeze_hold: assert property (!LOOP_ACTIVE |-> $stable(gains))
		else $error("gains moved while idle");
	a_step_frame: assert property ($changed(gains) |-> $past(FRAME_END))
		else $error("gain step without frame end");
	a_digital_last: assert property (DIGITAL_GAIN > $past(DIGITAL_GAIN) |->
		$past(GAIN_STAGE1) == `STAGE_MAX && $past(GAIN_STAGE2) == `STAGE_MAX)
		else $error("digital before stages");
	a_digital_step: assert property ($changed(DIGITAL_GAIN) |->
		DIGITAL_GAIN - $past(DIGITAL_GAIN) == `DGAIN_STEP ||
		$past(DIGITAL_GAIN) - DIGITAL_GAIN == `DGAIN_STEP)
		else $error("digital step size");
	a_digital_floor: assert property (DIGITAL_GAIN >= `RST_DGAIN)
		else $error("digital below unity");
	c_read: cover property (READ && $fell(WAITREQUEST));
	c_digital_up: cover property (DIGITAL_GAIN > $past(DIGITAL_GAIN));
	c_idle_frame: cover property (!LOOP_ACTIVE && FRAME_END);
endmodule // exposure_loop_asserts

// *** tb.sv ***
// self-checking bench for the exposure loop register bank
// assumes the design and checker files compiled alongside
`timescale 1ns/1ps
module tb;
	reg         CLK = 0, SYS_RST = 1, READ = 0, WRITE = 0, FRAME_END = 0;
	reg         PIX_VALID = 1;
	reg  [1:0]  PIX_COLOR = 0;
	reg  [3:0]  BYTEENABLE = 4'h3;
	reg  [9:0]  ADDRESS = 0, PIX_DATA = 10'h020;
	reg  [31:0] WRITEDATA = 0;
	wire [31:0] READDATA;
	wire        WAITREQUEST, LOOP_ACTIVE;
	wire [1:0]  GAIN_STAGE1, GAIN_STAGE2;
	wire [11:0] DIGITAL_GAIN;
	wire [9:0]  AVG_LEVEL;
	integer     n_mismatch = 0, n_compared = 0, cyc = 0, k;
	reg  [15:0] q;
	reg  [39:0] rows [0:6];
	reg  [1:0]  ph = 0;
	reg         sub_test = 0;
	exposure_loop_config_regs i_dut (
		.CLK          (CLK),
		.SYS_RST      (SYS_RST),
		.ADDRESS      (ADDRESS),
		.READ         (READ),
		.WRITE        (WRITE),
		.BYTEENABLE   (BYTEENABLE),
		.WRITEDATA    (WRITEDATA),
		.READDATA     (READDATA),
		.WAITREQUEST  (WAITREQUEST),
		.PIX_VALID    (PIX_VALID),
		.PIX_DATA     (PIX_DATA),
		.PIX_COLOR    (PIX_COLOR),
		.FRAME_END    (FRAME_END),
		.GAIN_STAGE1  (GAIN_STAGE1),
		.GAIN_STAGE2  (GAIN_STAGE2),
		.DIGITAL_GAIN (DIGITAL_GAIN),
		.AVG_LEVEL    (AVG_LEVEL),
		.LOOP_ACTIVE  (LOOP_ACTIVE)
	);
	// pixel pattern in step with the subsample counter: only phase 0 is bright
	always @(posedge CLK) begin
		ph <= SYS_RST ? 2'h0 : ph + 2'h1;
		if (sub_test)
			PIX_DATA <= (ph == 2'h3 && !SYS_RST) ? 10'h080 : 10'h000;
	end
	initial forever #50 CLK = ~CLK;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task xfer(input w, input [7:0] i, input [15:0] d);
		begin
			ADDRESS <= {i, 2'h0};
			WRITEDATA <= {16'h0000, d};
			WRITE <= w;
			READ <= !w;
			@(posedge CLK);
			while (WAITREQUEST !== 1'b0) @(posedge CLK);
			q = READDATA[15:0];
			WRITE <= 1'b0;
			READ <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task frame;
		begin
			FRAME_END <= 1'b1;
			@(posedge CLK);
			FRAME_END <= 1'b0;
			repeat (3) @(posedge CLK);
		end
	endtask
	task reset_dut;
		begin
			SYS_RST <= 1'b1;
			repeat (12) @(posedge CLK);
			SYS_RST <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task results;
		begin
			$display("compared %0d mismatches %0d", n_compared, n_mismatch);
			if (n_mismatch == 0 && n_compared > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_mismatch = n_mismatch + 1;
			results;
		end
	end
	initial begin
		rows[0] = {8'hA2, 16'h03FF, 16'h03FF};
		rows[1] = {8'hA3, 16'h0155, 16'h0155};
		rows[2] = {8'hA4, 16'h02AA, 16'h02AA};
		rows[3] = {8'hA5, 16'h0201, 16'h0201};
		rows[4] = {8'hA1, 16'h3DFF, 16'h3DFF};
		rows[5] = {8'h10, 16'h1234, 16'h0000};
		rows[6] = {8'hA0, 16'h0013, 16'h0011};
		reset_dut;
		for (k = 0; k < 6; k = k + 1) begin
			xfer(1'b0, 8'hA0 + k[7:0], 16'h0000);
			chk(q, k == 0 ? 16'h0010 : k == 1 ? 16'h60B8 : 16'h0080);
		end
		// register rows: write, read back
		for (k = 0; k < 7; k = k + 1) begin
			xfer(1'b1, rows[k][39:32], rows[k][31:16]);
			xfer(1'b0, rows[k][39:32], 16'h0000);
			chk(q, rows[k][15:0]);
		end
		repeat (150) @(posedge CLK);
		chk(LOOP_ACTIVE, 1'b1);
		chk(AVG_LEVEL, 10'h0FF);
		// stage 1 first, then stage 2, then digital
		for (k = 1; k < 8; k = k + 1) begin
			frame;
			chk({DIGITAL_GAIN, GAIN_STAGE2, GAIN_STAGE1}, {k > 6 ? 12'h084 : 12'h080,
				k > 6 ? 2'h3 : k > 3 ? k[1:0] + 2'h1 : 2'h0, k > 3 ? 2'h3 : k[1:0]});
		end
		xfer(1'b1, 8'hA0, 16'h0015);
		frame;
		chk(LOOP_ACTIVE, 1'b0);
		chk(DIGITAL_GAIN, 12'h084);
		reset_dut;
		xfer(1'b1, 8'hA1, 16'h3DFF);
		xfer(1'b1, 8'hA0, 16'h0001);
		repeat (150) @(posedge CLK);
		frame;
		chk({GAIN_STAGE2, GAIN_STAGE1}, 4'h4);
		chk(AVG_LEVEL, 10'h020);
		sub_test <= 1'b1;
		xfer(1'b1, 8'hA0, 16'h000B);
		repeat (600) @(posedge CLK);
		chk(AVG_LEVEL, 10'h080);
		results;
	end
endmodule // tb
bind exposure_loop_config_regs exposure_loop_asserts i_chk (
	.CLK          (CLK),
	.SYS_RST      (SYS_RST),
	.READ         (READ),
	.WRITE        (WRITE),
	.READDATA     (READDATA),
	.WAITREQUEST  (WAITREQUEST),
	.FRAME_END    (FRAME_END),
	.GAIN_STAGE1  (GAIN_STAGE1),
	.GAIN_STAGE2  (GAIN_STAGE2),
	.DIGITAL_GAIN (DIGITAL_GAIN),
	.LOOP_ACTIVE  (LOOP_ACTIVE)
);
